// ==== hdl/rdsq_pkg.sv ====
// Constants and types for the read burst sequencer
// Contract
// - Per-command mode: length bit low chops, high full
// - Burst field 00 fixed eight, 01 per-command
// - Field 10, or 01 with bit low, chops
// - Auto-precharge bit low: bank stays open
// - Auto-precharge bit high: precharge after burst
// - Data starts cas plus additive latency later
// - Write latency is write cas plus additive
// - A read four clocks after an eight-beat read streams without gap
// - Release data pins at latency plus four/two
package rdsq_pkg;
    localparam logic [1:0] BURST_FIXED_EIGHT = 2'h0;
    localparam logic [1:0] BURST_PER_COMMAND = 2'h1;
    localparam logic [1:0] BURST_FIXED_CHOP  = 2'h2;
    localparam logic [2:0] CLKS_EIGHT_BEAT   = 3'h4;
    localparam logic [2:0] CLKS_CHOPPED      = 3'h2;
    localparam logic [1:0] PRE_SHORT_CLKS    = 2'h1;
    localparam logic [1:0] PRE_LONG_CLKS     = 2'h2;
    localparam int         LAT_W             = 7;

    typedef struct packed {
        logic       v;
        logic       chop;
        logic       ap;
        logic [1:0] bg;
        logic [1:0] bank;
    } rdsq_entry_t;

    localparam rdsq_entry_t ENTRY_RST = '0;
    localparam logic [2:0]  LEFT_RST  = 3'h0;
    localparam logic [1:0]  PRE_RST   = 2'h0;
endpackage : rdsq_pkg

// ==== hdl/rdsq_pipe_if.sv ====
// Carrier between the sequencer and its latency delay line
interface rdsq_pipe_if;
    logic                          tick;
    logic                          insert;
    logic [rdsq_pkg::LAT_W-1:0]    latency;
    rdsq_pkg::rdsq_entry_t         ins;
    logic [1:0]                    pre_len;
    rdsq_pkg::rdsq_entry_t         head;
    rdsq_pkg::rdsq_entry_t         peek;
    modport seq  (output tick, insert, latency, ins, pre_len, input head, peek);
    modport pipe (input tick, insert, latency, ins, pre_len, output head, peek);
endinterface : rdsq_pipe_if

// ==== hdl/rdsq_lat_pipe.sv ====
// Clock-counted delay line holding reads until their latency expires
module rdsq_lat_pipe #(
    parameter int DEPTH = 128
) (
    input wire logic    mclk,
    input wire logic    reset_n,
    rdsq_pipe_if.pipe   p
);
    rdsq_pkg::rdsq_entry_t line_q [DEPTH];

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_slot
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    line_q[i] <= rdsq_pkg::ENTRY_RST;
                end else if (p.tick) begin
                    if (p.insert && int'(p.latency) == i + 1) begin
                        line_q[i] <= p.ins;
                    end else begin
                        if (i == DEPTH - 1) begin
                            line_q[i] <= rdsq_pkg::ENTRY_RST;
                        end else begin
                            line_q[i] <= line_q[(i + 1) % DEPTH];
                        end
                    end
                end
            end
        end
    endgenerate

    assign p.head = line_q[0];
    assign p.peek = line_q[p.pre_len];

    // Helper: slot that a read entered on the last clock
    logic [rdsq_pkg::LAT_W-1:0] slot_q;
    logic                       ins_q;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            slot_q <= '0;
            ins_q  <= 1'b0;
        end else begin
            slot_q <= p.latency - 7'h1;
            ins_q  <= p.tick && p.insert && p.latency != 7'h0;
        end
    end

    AST_LAT_SLOT: assert property (@(posedge mclk) disable iff (!reset_n)
        ins_q |-> line_q[slot_q].v)
        else $error("read not queued at its latency slot");
endmodule : rdsq_lat_pipe

// ==== hdl/rdsq_read_seq.sv ====
// Read burst sequencer: length, latency, preamble, data drive, auto precharge
module rdsq_read_seq #(
    parameter int DQ_W  = 8,
    parameter int DEPTH = 128
) (
    input  wire logic            mclk,
    input  wire logic            reset_n,
    input  wire logic            ck,
    input  wire logic            cmd_read,
    input  wire logic            length_select_address_bit,
    input  wire logic            autoprecharge_address_bit,
    input  wire logic [1:0]      bank_group,
    input  wire logic [1:0]      bank,
    input  wire logic [1:0]      mode_register_zero_burst,
    input  wire logic [5:0]      cas_latency,
    input  wire logic [5:0]      additive_latency,
    input  wire logic [5:0]      write_cas_latency,
    input  wire logic            preamble_two_clk,
    input  wire logic [DQ_W-1:0] array_data,
    output logic                 beat_take,
    output logic [6:0]           read_latency,
    output logic [6:0]           write_latency,
    input  wire logic [DQ_W-1:0] dq_i,
    output logic [DQ_W-1:0]      dq_o,
    output logic                 dq_oe_n,
    input  wire logic            dqs_i,
    output logic                 dqs_o,
    output logic                 dqs_oe_n,
    output logic                 precharge_req,
    output logic [1:0]           precharge_bg,
    output logic [1:0]           precharge_bank
);
    rdsq_pipe_if pif ();

    rdsq_lat_pipe #(.DEPTH(DEPTH)) u_pipe (
        .mclk    (mclk),
        .reset_n (reset_n),
        .p       (pif)
    );

    // Link clock and command pins, two stages each
    logic [7:0] sync1_q;
    logic [7:0] sync2_q;
    logic       ck_last_q;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q   <= 8'h00;
            sync2_q   <= 8'h00;
            ck_last_q <= 1'b0;
        end else begin
            sync1_q   <= {ck, cmd_read, length_select_address_bit,
                          autoprecharge_address_bit, bank_group, bank};
            sync2_q   <= sync1_q;
            ck_last_q <= sync2_q[7];
        end
    end

    logic ck_rise;
    logic ck_fall;
    logic rd_take;
    assign ck_rise = sync2_q[7] && !ck_last_q;
    assign ck_fall = !sync2_q[7] && ck_last_q;
    assign rd_take = ck_rise && sync2_q[6];

    // Burst length per command
    logic chop_d;
    always_comb begin
        if (mode_register_zero_burst == rdsq_pkg::BURST_PER_COMMAND) begin
            chop_d = !sync2_q[5];
        end else if (mode_register_zero_burst == rdsq_pkg::BURST_FIXED_CHOP) begin
            chop_d = 1'b1;
        end else begin
            chop_d = 1'b0;
        end
    end

    logic [6:0] rdlat_d;
    assign rdlat_d = {1'b0, cas_latency} + {1'b0, additive_latency};

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            read_latency  <= 7'h00;
            write_latency <= 7'h00;
        end else begin
            read_latency  <= rdlat_d;
            write_latency <= {1'b0, write_cas_latency} + {1'b0, additive_latency};
        end
    end

    assign pif.tick    = ck_rise;
    assign pif.insert  = rd_take;
    assign pif.latency = rdlat_d;
    assign pif.ins     = '{v: 1'b1, chop: chop_d, ap: sync2_q[4],
                           bg: sync2_q[3:2], bank: sync2_q[1:0]};
    assign pif.pre_len = preamble_two_clk ? rdsq_pkg::PRE_LONG_CLKS
                                          : rdsq_pkg::PRE_SHORT_CLKS;

    // Burst drive state, counted in link clocks
    logic [2:0]            left_q;
    logic [2:0]            left_d;
    logic                  load;
    logic                  seamless;
    rdsq_pkg::rdsq_entry_t cur_q;
    assign load     = ck_rise && pif.head.v;
    assign seamless = load && left_q == 3'h1;

    always_comb begin
        left_d = left_q;
        if (load) begin
            left_d = pif.head.chop ? rdsq_pkg::CLKS_CHOPPED
                                   : rdsq_pkg::CLKS_EIGHT_BEAT;
        end else if (ck_rise && left_q != 3'h0) begin
            left_d = left_q - 3'h1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            left_q <= rdsq_pkg::LEFT_RST;
        end else begin
            left_q <= left_d;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cur_q <= rdsq_pkg::ENTRY_RST;
        end else if (load) begin
            cur_q <= pif.head;
        end
    end

    // Auto precharge once the current burst's last clock has passed
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            precharge_req  <= 1'b0;
            precharge_bg   <= 2'h0;
            precharge_bank <= 2'h0;
        end else begin
            precharge_req <= ck_rise && left_q == 3'h1 && cur_q.ap;
            if (ck_rise && left_q == 3'h1) begin
                precharge_bg   <= cur_q.bg;
                precharge_bank <= cur_q.bank;
            end
        end
    end

    // Burst due in pre_len clocks that will not join on: seamless only
    // when the current burst has exactly pre_len plus one clocks left
    logic gap_ahead;
    assign gap_ahead = pif.peek.v && ({1'b0, left_q} != {2'b00, pif.pre_len} + 4'h1);

    // Strobe preamble ahead of a burst that does not follow seamlessly
    logic [1:0] pre_q;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pre_q <= rdsq_pkg::PRE_RST;
        end else if (ck_rise) begin
            if (gap_ahead) begin
                pre_q <= pif.pre_len;
            end else if (pre_q != 2'h0) begin
                pre_q <= pre_q - 2'h1;
            end
        end
    end

    logic active_edge;
    assign active_edge = (ck_rise && left_d != 3'h0) || (ck_fall && left_q != 3'h0);
    assign beat_take   = active_edge;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dq_o     <= '0;
            dqs_o    <= 1'b0;
            dq_oe_n  <= 1'b1;
            dqs_oe_n <= 1'b1;
        end else begin
            if (active_edge) begin
                dq_o  <= array_data;
                dqs_o <= !dqs_o;
            end else if (ck_rise && left_d == 3'h0) begin
                dqs_o <= 1'b0;
            end
            if (ck_rise) begin
                dq_oe_n  <= left_d == 3'h0;
                dqs_oe_n <= left_d == 3'h0 && pre_q == 2'h0 && !gap_ahead;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    AST_PERCMD_LEN: assert property (
        rd_take && mode_register_zero_burst == rdsq_pkg::BURST_PER_COMMAND
        |-> pif.ins.chop == !sync2_q[5])
        else $error("per-command length bit not honoured");
    AST_FIXED_EIGHT: assert property (
        rd_take && mode_register_zero_burst == rdsq_pkg::BURST_FIXED_EIGHT |-> !chop_d)
        else $error("fixed eight-beat mode chopped a read");
    AST_CHOP_CLKS: assert property (
        load && pif.head.chop |=> left_q == 3'h2 ##0 !dq_oe_n)
        else $error("chopped burst not two clocks");
    AST_EIGHT_CLKS: assert property (
        load && !pif.head.chop |=> left_q == 3'h4)
        else $error("eight-beat burst not four clocks");
    AST_RELEASE: assert property (
        $rose(dq_oe_n) |-> $past(ck_rise) && $past(left_q) == 3'h1)
        else $error("data pins released at wrong clock");
    AST_NO_AP: assert property (
        precharge_req |-> $past(cur_q.ap) && $past(left_q) == 3'h1)
        else $error("precharge without auto-precharge read");
    AST_AP: assert property (
        ck_rise && left_q == 3'h1 && cur_q.ap |=> precharge_req && precharge_bank == $past(cur_q.bank))
        else $error("auto precharge missed after burst");
    AST_DDR_BEATS: assert property (
        ck_fall && left_q != 3'h0 |=> dqs_o != $past(dqs_o) && !dq_oe_n)
        else $error("no beat on falling clock edge");
    AST_SEAMLESS: assert property (
        seamless |=> !dq_oe_n && left_q != 3'h0)
        else $error("gap between back-to-back bursts");
    AST_PREAMBLE: assert property (
        $fell(dq_oe_n) |-> !dqs_oe_n && $past(pre_q) != 2'h0)
        else $error("burst started without strobe preamble");

    COV_EIGHT: cover property (load && !pif.head.chop);
    COV_CHOP: cover property (load && pif.head.chop);
    COV_SEAMLESS: cover property (seamless);
    COV_AP: cover property (precharge_req);
endmodule : rdsq_read_seq

// ==== verification/rdsq_ctrl_model.sv ====
// Controller-side model: link clock and read commands
module rdsq_ctrl_model (
    output logic       ck,
    output logic       cmd_read,
    output logic       lsel,
    output logic       ap,
    output logic [1:0] bg,
    output logic [1:0] bk
);
    timeunit 1ns;
    timeprecision 1ps;

    // Link clock runs free, phase unrelated to mclk
    initial begin
        ck = 1'b0;
        #37;
        forever #80 ck = ~ck;
    end

    initial begin
        cmd_read = 1'b0;
        lsel     = 1'b0;
        ap       = 1'b0;
        bg       = 2'h0;
        bk       = 2'h0;
    end

    // Caller spaces commands by one read or four clocks only
    // Issues no writes or precharges, so turnaround rules hold
    task read_cmd(input logic lbit, input logic apbit, input logic [1:0] g, input logic [1:0] b);
        @(negedge ck);
        cmd_read = 1'b1;
        lsel     = lbit;
        ap       = apbit;
        bg       = g;
        bk       = b;
        @(negedge ck);
        cmd_read = 1'b0;
        // Released lines show the inverse of the last value
        lsel     = ~lsel;
        ap       = ~ap;
        bg       = ~bg;
        bk       = ~bk;
    endtask : read_cmd
endmodule : rdsq_ctrl_model

// ==== verification/rdsq_read_seq_bench.sv ====
// Self-checking bench for the read burst sequencer
module rdsq_read_seq_bench;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        logic [1:0] mode;
        logic       lbit;
        logic       apbit;
        logic [1:0] g;
        logic [1:0] b;
        logic [7:0] n;
    } rdsq_row_t;

    logic       mclk = 1'b0;
    logic       reset_n = 1'b0;
    logic [1:0] mode = 2'h0;
    logic       pre2 = 1'b0;
    logic [7:0] adata = 8'h00;
    logic       ck, cmd, lsel, ap, beat_take, dq_oe_n, dqs_o, dqs_oe_n, pc_req;
    logic       prev_oe = 1'b1;
    logic [1:0] bg, bk, pc_bg, pc_bk, last_bg, last_bk;
    logic [6:0] rdlat_o, wrlat_o;
    logic [5:0] cas_lat = 6'h05;
    logic [5:0] add_lat = 6'h02;
    logic [5:0] wcas_lat = 6'h04;
    logic       took = 1'b0;
    logic       beat_dqs = 1'b0;
    logic [7:0] beat_dat = 8'h00;
    logic [7:0] dq_o;
    int         fail_count = 0;
    int         comparisons = 0;
    int         cycles = 0;
    int         ck_n, lat, beats, drv, pre, falls, pcs;
    rdsq_row_t  rows [5] = '{
        '{2'h0, 1'b0, 1'b0, 2'h0, 2'h1, 8'h08},
        '{2'h1, 1'b1, 1'b1, 2'h2, 2'h3, 8'h08},
        '{2'h1, 1'b0, 1'b0, 2'h1, 2'h0, 8'h04},
        '{2'h2, 1'b1, 1'b1, 2'h3, 2'h2, 8'h04},
        '{2'h3, 1'b0, 1'b1, 2'h1, 2'h1, 8'h08}};

    rdsq_ctrl_model mdl (.ck(ck), .cmd_read(cmd), .lsel(lsel), .ap(ap), .bg(bg), .bk(bk));

    rdsq_read_seq #(.DQ_W(8), .DEPTH(128)) dut (
        .mclk(mclk), .reset_n(reset_n), .ck(ck), .cmd_read(cmd),
        .length_select_address_bit(lsel), .autoprecharge_address_bit(ap),
        .bank_group(bg), .bank(bk), .mode_register_zero_burst(mode),
        .cas_latency(cas_lat), .additive_latency(add_lat), .write_cas_latency(wcas_lat),
        .preamble_two_clk(pre2), .array_data(adata), .beat_take(beat_take),
        .read_latency(rdlat_o), .write_latency(wrlat_o), .dq_i(8'h00), .dq_o(dq_o),
        .dq_oe_n(dq_oe_n), .dqs_i(1'b0), .dqs_o(dqs_o), .dqs_oe_n(dqs_oe_n),
        .precharge_req(pc_req), .precharge_bg(pc_bg), .precharge_bank(pc_bk));

    always #10 mclk = ~mclk;

    always @(posedge mclk) begin
        #1 adata = adata + 8'h01;
    end

    always @(negedge mclk) begin
        cycles++;
        if (took === 1'b1 && reset_n === 1'b1) begin
            chk(dq_o, beat_dat, "beat data");
            chk({7'h0, dqs_o}, {7'h0, ~beat_dqs}, "strobe toggle");
        end
        took     = beat_take;
        beat_dat = adata;
        beat_dqs = dqs_o;
        if (beat_take === 1'b1) beats++;
        if (pc_req === 1'b1) begin
            pcs++;
            last_bg = pc_bg;
            last_bk = pc_bk;
        end
        if (prev_oe === 1'b1 && dq_oe_n === 1'b0) falls++;
        prev_oe = dq_oe_n;
        if (cycles == 5000) begin
            fail_count++;
            test_done();
        end
    end

    always @(posedge ck) ck_n++;

    always @(negedge ck) begin
        if (dq_oe_n === 1'b0) begin
            drv++;
            if (drv == 1) lat = ck_n;
        end
        if (dqs_oe_n === 1'b0 && dq_oe_n === 1'b1) begin
            pre++;
            chk({7'h0, dqs_o}, 8'h00, "preamble level");
        end
    end

    task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk

    task clear;
        ck_n = 0; lat = 0; beats = 0; drv = 0; pre = 0; falls = 0; pcs = 0;
    endtask : clear

    task test_done;
        if (fail_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : test_done

    initial begin
        repeat (3) @(posedge mclk);
        chk({7'h0, dq_oe_n}, 8'h01, "data drive in reset");
        chk({7'h0, dqs_oe_n}, 8'h01, "strobe drive in reset");
        chk({7'h0, pc_req}, 8'h00, "precharge in reset");
        #1 reset_n = 1'b1;
        repeat (4) @(posedge mclk);
        chk({1'b0, rdlat_o}, 8'h07, "read latency");
        chk({1'b0, wrlat_o}, 8'h06, "write latency");
        for (int i = 0; i < 5; i++) begin
            @(posedge mclk) #1 mode = rows[i].mode;
            mdl.read_cmd(rows[i].lbit, rows[i].apbit, rows[i].g, rows[i].b);
            clear();
            repeat (12) @(posedge ck);
            chk(8'(beats), rows[i].n, "beats");
            chk(8'(lat), 8'h07, "latency");
            chk(8'(drv), rows[i].n >> 1, "drive clocks");
            chk(8'(pre), 8'h01, "preamble");
            chk(8'(pcs), {7'h0, rows[i].apbit}, "precharge count");
            if (rows[i].apbit) chk({4'h0, last_bg, last_bk}, {4'h0, rows[i].g, rows[i].b}, "bank");
        end
        // Seamless pair four clocks apart, long preamble, eight then chop
        @(posedge mclk) #1 mode = 2'h1;
        pre2 = 1'b1;
        add_lat = 6'h04;
        mdl.read_cmd(1'b1, 1'b0, 2'h0, 2'h1);
        clear();
        repeat (2) @(negedge ck);
        mdl.read_cmd(1'b0, 1'b1, 2'h1, 2'h2);
        repeat (12) @(posedge ck);
        chk(8'(beats), 8'h0c, "seamless beats");
        chk(8'(falls), 8'h01, "seamless gap");
        chk(8'(drv), 8'h06, "seamless drive");
        chk(8'(pre), 8'h02, "long preamble");
        chk(8'(lat), 8'h09, "seamless latency");
        chk({1'b0, rdlat_o}, 8'h09, "read latency, larger additive");
        chk({1'b0, wrlat_o}, 8'h08, "write latency, larger additive");
        chk(8'(pcs), 8'h01, "seamless precharge");
        chk({4'h0, last_bg, last_bk}, 8'h06, "seamless bank");
        // Reset in mid-burst releases the pins
        mdl.read_cmd(1'b1, 1'b1, 2'h2, 2'h0);
        repeat (10) @(posedge ck);
        @(posedge mclk) #1 chk({7'h0, dq_oe_n}, 8'h00, "burst under way");
        reset_n = 1'b0;
        @(negedge mclk);
        chk({7'h0, dq_oe_n}, 8'h01, "data drive after reset");
        chk({7'h0, dqs_oe_n}, 8'h01, "strobe drive after reset");
        chk({7'h0, pc_req}, 8'h00, "precharge after reset");
        repeat (2) @(posedge mclk);
        #1 reset_n = 1'b1;
        // Fresh chopped read after the mid-run reset
        mdl.read_cmd(1'b0, 1'b0, 2'h3, 2'h1);
        clear();
        repeat (12) @(posedge ck);
        chk(8'(beats), 8'h04, "beats after reset");
        chk(8'(lat), 8'h09, "latency after reset");
        chk(8'(pre), 8'h02, "preamble after reset");
        chk(8'(pcs), 8'h00, "precharge count after reset");
        test_done();
    end
endmodule : rdsq_read_seq_bench
